/* logic/burst_addr_counter.sv */
// Purpose: two-bit burst address counter in wrapping order
// Assumes: load and step never both matter; load wins
// Notes:   address is start xor index, which yields the wrapping order
`timescale 1ns/1ns
`default_nettype none
module burst_addr_counter (
  // clock and reset
  input  wire logic   ref_clk,
  input  wire logic   srst,
  input  wire logic   clk_en,
  // control from the glue
  burst_ctr_if.ctr    bus
);

  logic [1:0] start_q;
  logic [1:0] start_d;
  logic [1:0] idx_q;
  logic [1:0] idx_d;
  logic [1:0] addr_q;
  logic [1:0] addr_d;

  // ==========================================================================
  // next start, index and address
  // ==========================================================================
  always_comb
  begin
    start_d = start_q;
    idx_d   = idx_q;
    if (bus.load)
    begin
      start_d = bus.start_addr;
      idx_d   = bus.inc_on_load ? glue_pkg::BURST_FIRST_STEP : glue_pkg::RST_BURST_ADDR;
    end
    else if (bus.step)
    begin
      idx_d = idx_q + glue_pkg::BURST_FIRST_STEP;  // wraps after four
    end
    addr_d = start_d ^ idx_d;
  end

  // registered so the flash address lines never glitch
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      start_q <= glue_pkg::RST_BURST_ADDR;
      idx_q   <= glue_pkg::RST_BURST_ADDR;
      addr_q  <= glue_pkg::RST_BURST_ADDR;
    end
    else if (clk_en)
    begin
      start_q <= start_d;
      idx_q   <= idx_d;
      addr_q  <= addr_d;
    end
  end

  assign bus.addr = addr_q;

  // ==========================================================================
  // checks
  // ==========================================================================
  property p_burst_order;
    @(posedge ref_clk) disable iff (srst || !clk_en)
    (!bus.load && bus.step) |=> addr_q == (start_q ^ ($past(idx_q) + 2'h1));
  endproperty
  a_burst_order: assert property (p_burst_order) else $error("burst address left wrap order");

  property p_load_first;
    @(posedge ref_clk) disable iff (srst || !clk_en)
    bus.load |=> addr_q == ($past(bus.start_addr) ^ {1'b0, $past(bus.inc_on_load)});
  endproperty
  a_load_first: assert property (p_load_first) else $error("counter load gave wrong address");

endmodule
`default_nettype wire

/* logic/burst_ctr_if.sv */
// Purpose: carrier between the glue state machine and its burst counter
// Assumes: driven on ref_clk
// Notes:   addr is the flash low address when the counter path is selected
`timescale 1ns/1ns
`default_nettype none
interface burst_ctr_if;
  logic       load;         // take start_addr
  logic       inc_on_load;  // first address already sent by the processor
  logic       step;         // advance in wrapping burst order
  logic [1:0] start_addr;
  logic [1:0] addr;

  modport ctl (output load, output inc_on_load, output step, output start_addr, input addr);
  modport ctr (input load, input inc_on_load, input step, input start_addr, output addr);
endinterface
`default_nettype wire

/* logic/glue_pkg.sv */
// Purpose: shared constants and state encoding of the flash burst glue
// Assumes: one processor clock; flash runs on a delayed copy of it
// Notes:   outputs are active low where the name ends in _n
package glue_pkg;

  // ==========================================================================
  // cycle counts of the optimized read and of the write
  // ==========================================================================
  localparam logic [1:0] ADV_HOLD_CYCLES = 2'h3;  // address-valid low after launch
  localparam logic [1:0] WE_LOW_CYCLES   = 2'h2;  // write strobe low time
  localparam logic [1:0] ADV_TIMER_LOAD  = ADV_HOLD_CYCLES - 2'h1;
  localparam logic [1:0] WE_TIMER_LOAD   = WE_LOW_CYCLES - 2'h1;
  localparam logic [1:0] CPU_BURST_READY_N_AT_COUNT   = 2'h1;  // timer value one clock before ready drops

  // ==========================================================================
  // values after reset
  // ==========================================================================
  localparam logic       RST_ADDR_VALID_N = 1'b0;  // idle anticipation
  localparam logic       RST_PATH_SELECT  = 1'b1;  // processor address path
  localparam logic       RST_CHIP_EN_N    = 1'b0;
  localparam logic       RST_STROBE_N     = 1'b1;  // oe, we, ready, cacheable
  localparam logic [1:0] RST_BURST_ADDR   = 2'h0;
  localparam logic [1:0] BURST_FIRST_STEP = 2'h1;

  // ==========================================================================
  // glue state machine, gray coded along read and write paths except ST_RD_ADDR to ST_RD_END and returns to idle from ST_RD_END, ST_WR_READY or back-off
  // ==========================================================================
  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_RD_CTL   = 4'h1,
    ST_RD_ADDR  = 4'h3,
    ST_RD_DATA  = 4'h2,
    ST_RD_END   = 4'h6,
    ST_WR_LOAD  = 4'h8,
    ST_WR_CTL   = 4'h9,
    ST_WR_PULSE = 4'hB,
    ST_WR_READY = 4'hA
  } glue_state_e;

endpackage

/* logic/phase_timer.sv */
// Purpose: small down counter that times strobe windows
// Assumes: load value fits two bits
// Notes:   stops at zero; done is a plain decode of the count
`timescale 1ns/1ns
`default_nettype none
module phase_timer (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       srst,
  input  wire logic       clk_en,
  // control
  input  wire logic       load,
  input  wire logic [1:0] load_val,
  // state
  output logic      [1:0] count,
  output logic            done
);

  logic [1:0] count_q;
  logic [1:0] count_d;

  // count down to zero and hold there
  always_comb
  begin
    count_d = count_q;
    if (load)
      count_d = load_val;
    else if (count_q != 2'h0)
      count_d = count_q - 2'h1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      count_q <= 2'h0;
    else if (clk_en)
      count_q <= count_d;
  end

  assign count = count_q;
  assign done  = (count_q == 2'h0);

endmodule
`default_nettype wire

/* logic/sync_flash_cpu_burst_glue.sv */
// Purpose: glue between a 32-bit burst processor bus and synchronous flash
// Assumes: all processor inputs are on ref_clk; flash clock is a delayed copy
// Notes:   optimized read timing and non-burst double-word writes only
// Behaviour
// - idle keeps address-valid and processor path
// - chip enable stays asserted while idle
// - configuration high runs cacheable burst reads
// - strobe low with read enters read
// - miss decode in read returns idle
// - launch: load counter, select counter, valid three
// - counter steps while address-valid low
// - burst addresses follow wrapping xor order
// - cacheable asserted from N=2 to end
// - output enable from N=2 whole burst
// - burst-ready low from N=3 through burst
// - burst-last ends: ready high, then idle
// - strobe low with write enters write
// - write uses counter path, one address
// - double-word writes, one at a time
// - write strobe low two clocks, high N=4
// - ready after N=4, idle at N=5
// - back-off in read drops output enable
`timescale 1ns/1ns
`default_nettype none
module sync_flash_cpu_burst_glue (
  // clock, reset, enable
  input  wire logic       ref_clk,
  input  wire logic       srst,
  input  wire logic       clk_en,
  // processor bus
  input  wire logic       cpu_addr_strobe_n,
  input  wire logic       cpu_write_read,
  input  wire logic       cpu_burst_last_n,
  input  wire logic       cpu_backoff_n,
  input  wire logic [1:0] cpu_low_addr,
  output logic            cpu_burst_ready_n,
  output logic            cpu_cacheable_n,
  // decode and configuration
  input  wire logic       flash_space_miss,
  input  wire logic       flash_read_latency_setting,
  // flash control
  output logic            flash_addr_valid_n,
  output logic            low_addr_path_select,
  output logic            flash_chip_enable_n,
  output logic            flash_output_enable_n,
  output logic            flash_write_enable_n,
  output logic      [1:0] flash_low_addr
);

  glue_pkg::glue_state_e state_q;
  glue_pkg::glue_state_e state_d;
  logic       adv_n_q;
  logic       adv_n_d;
  logic       sel_q;
  logic       sel_d;
  logic       ce_n_q;
  logic       ce_n_d;
  logic       oe_n_q;
  logic       oe_n_d;
  logic       we_n_q;
  logic       we_n_d;
  logic       cpu_burst_ready_n_n_q;
  logic       cpu_burst_ready_n_n_d;
  logic       ken_n_q;
  logic       ken_n_d;
  logic       tmr_load;
  logic [1:0] tmr_val;
  logic [1:0] tmr_count;
  logic       tmr_done;
  logic       backoff;
  logic       burst_end;

  burst_ctr_if ctr_bus ();

  // ==========================================================================
  // helpers
  // ==========================================================================
  burst_addr_counter u_counter (
    .ref_clk (ref_clk),
    .srst    (srst),
    .clk_en  (clk_en),
    .bus     (ctr_bus)
  );

  phase_timer u_timer (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .clk_en   (clk_en),
    .load     (tmr_load),
    .load_val (tmr_val),
    .count    (tmr_count),
    .done     (tmr_done)
  );

  assign backoff   = !cpu_backoff_n;
  assign burst_end = !cpu_burst_ready_n_n_q && !cpu_burst_last_n;
  // counter always sees the processor low address; only its load strobe matters
  assign ctr_bus.start_addr = cpu_low_addr;

  // ==========================================================================
  // state machine: next state and next outputs
  // ==========================================================================
  always_comb
  begin
    state_d  = state_q;
    adv_n_d  = adv_n_q;
    sel_d    = sel_q;
    ce_n_d   = 1'b0;
    oe_n_d   = oe_n_q;
    we_n_d   = we_n_q;
    cpu_burst_ready_n_n_d = cpu_burst_ready_n_n_q;
    ken_n_d  = ken_n_q;
    tmr_load = 1'b0;
    tmr_val  = 2'h0;
    ctr_bus.load        = 1'b0;
    ctr_bus.inc_on_load = 1'b0;
    ctr_bus.step        = 1'b0;
    unique case (state_q)
      glue_pkg::ST_IDLE:
      begin
        adv_n_d  = 1'b0;
        sel_d    = 1'b1;
        oe_n_d   = 1'b1;
        we_n_d   = 1'b1;
        cpu_burst_ready_n_n_d = 1'b1;
        ken_n_d  = 1'b1;
        if (!cpu_addr_strobe_n && !backoff)
        begin
          if (cpu_write_read)
          begin
            // configuration is not looked at for writes
            state_d      = glue_pkg::ST_WR_LOAD;
            ctr_bus.load = 1'b1;
            sel_d        = 1'b0;
            adv_n_d      = 1'b1;
          end
          else
            state_d = glue_pkg::ST_RD_CTL;
        end
      end
      glue_pkg::ST_RD_CTL:
      begin
        // slow latency setting is not served: such a read falls back to idle
        if (flash_space_miss || !flash_read_latency_setting)
          state_d = glue_pkg::ST_IDLE;
        else
        begin
          state_d             = glue_pkg::ST_RD_ADDR;
          ctr_bus.load        = 1'b1;
          ctr_bus.inc_on_load = 1'b1;
          sel_d               = 1'b0;
          adv_n_d             = 1'b0;
          tmr_load            = 1'b1;
          tmr_val             = glue_pkg::ADV_TIMER_LOAD;
        end
      end
      glue_pkg::ST_RD_ADDR:
      begin
        if (tmr_done)
        begin
          adv_n_d = 1'b1;
          state_d = glue_pkg::ST_RD_DATA;
        end
        else
          ctr_bus.step = 1'b1;
        if (tmr_count == glue_pkg::ADV_TIMER_LOAD)
        begin
          oe_n_d  = 1'b0;
          ken_n_d = 1'b0;
        end
        if (tmr_count == glue_pkg::CPU_BURST_READY_N_AT_COUNT)
          cpu_burst_ready_n_n_d = 1'b0;
        if (burst_end)
        begin
          cpu_burst_ready_n_n_d = 1'b1;
          ken_n_d  = 1'b1;
          adv_n_d  = 1'b1;
          state_d  = glue_pkg::ST_RD_END;
        end
      end
      glue_pkg::ST_RD_DATA:
      begin
        if (burst_end)
        begin
          cpu_burst_ready_n_n_d = 1'b1;
          ken_n_d  = 1'b1;
          state_d  = glue_pkg::ST_RD_END;
        end
      end
      glue_pkg::ST_RD_END:
      begin
        // output enable outlives ready by one clock for processor data hold
        oe_n_d  = 1'b1;
        adv_n_d = 1'b0;
        sel_d   = 1'b1;
        state_d = glue_pkg::ST_IDLE;
      end
      glue_pkg::ST_WR_LOAD:
      begin
        if (flash_space_miss)
        begin
          sel_d   = 1'b1;
          adv_n_d = 1'b0;
          state_d = glue_pkg::ST_IDLE;
        end
        else
          state_d = glue_pkg::ST_WR_CTL;
      end
      glue_pkg::ST_WR_CTL:
      begin
        we_n_d   = 1'b0;
        tmr_load = 1'b1;
        tmr_val  = glue_pkg::WE_TIMER_LOAD;
        state_d  = glue_pkg::ST_WR_PULSE;
      end
      glue_pkg::ST_WR_PULSE:
      begin
        if (tmr_done)
        begin
          we_n_d   = 1'b1;
          cpu_burst_ready_n_n_d = 1'b0;
          state_d  = glue_pkg::ST_WR_READY;
        end
      end
      glue_pkg::ST_WR_READY:
      begin
        // single ready: only double-word writes are supported
        cpu_burst_ready_n_n_d = 1'b1;
        adv_n_d  = 1'b0;
        sel_d    = 1'b1;
        state_d  = glue_pkg::ST_IDLE;
      end
      default:
        state_d = glue_pkg::ST_IDLE;
    endcase
    // back-off aborts any cycle; the processor restarts it later
    if (backoff)
    begin
      state_d  = glue_pkg::ST_IDLE;
      adv_n_d  = 1'b0;
      sel_d    = 1'b1;
      // chip enable stays low: the idle state must keep the flash selected
      oe_n_d   = 1'b1;
      we_n_d   = 1'b1;
      cpu_burst_ready_n_n_d = 1'b1;
      ken_n_d  = 1'b1;
    end
  end

  // register state and strobes
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      state_q  <= glue_pkg::ST_IDLE;
      adv_n_q  <= glue_pkg::RST_ADDR_VALID_N;
      sel_q    <= glue_pkg::RST_PATH_SELECT;
      ce_n_q   <= glue_pkg::RST_CHIP_EN_N;
      oe_n_q   <= glue_pkg::RST_STROBE_N;
      we_n_q   <= glue_pkg::RST_STROBE_N;
      cpu_burst_ready_n_n_q <= glue_pkg::RST_STROBE_N;
      ken_n_q  <= glue_pkg::RST_STROBE_N;
    end
    else if (clk_en)
    begin
      state_q  <= state_d;
      adv_n_q  <= adv_n_d;
      sel_q    <= sel_d;
      ce_n_q   <= ce_n_d;
      oe_n_q   <= oe_n_d;
      we_n_q   <= we_n_d;
      cpu_burst_ready_n_n_q <= cpu_burst_ready_n_n_d;
      ken_n_q  <= ken_n_d;
    end
  end

  // ==========================================================================
  // outputs; oe and we also drop within the back-off cycle itself
  // ==========================================================================
  assign flash_addr_valid_n    = adv_n_q;
  assign low_addr_path_select  = sel_q;
  assign flash_chip_enable_n   = ce_n_q;
  assign flash_output_enable_n = oe_n_q | backoff;
  assign flash_write_enable_n  = we_n_q | backoff;
  assign cpu_burst_ready_n     = cpu_burst_ready_n_n_q;
  assign cpu_cacheable_n       = ken_n_q;
  assign flash_low_addr        = sel_q ? cpu_low_addr : ctr_bus.addr;

  // ==========================================================================
  // checks
  // ==========================================================================
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst || !clk_en);

  property p_idle_anticipate;
    (state_q == glue_pkg::ST_IDLE && $past(state_q) == glue_pkg::ST_IDLE) |-> !adv_n_q && sel_q;
  endproperty
  a_idle_anticipate: assert property (p_idle_anticipate) else $error("idle without anticipation");

  property p_idle_chip_enable;
    (state_q == glue_pkg::ST_IDLE) |-> !flash_chip_enable_n;
  endproperty
  a_idle_chip_enable: assert property (p_idle_chip_enable) else $error("chip enable off in idle");

  property p_read_miss;
    (state_q == glue_pkg::ST_RD_CTL && flash_space_miss) |=> state_q == glue_pkg::ST_IDLE && oe_n_q;
  endproperty
  a_read_miss: assert property (p_read_miss) else $error("miss did not return to idle");

  property p_adv_window;
    (state_q == glue_pkg::ST_RD_CTL && !flash_space_miss && flash_read_latency_setting && cpu_backoff_n)
      ##1 cpu_backoff_n[*3] |=> adv_n_q && $past(adv_n_q, 3) == 1'b0 && !sel_q;
  endproperty
  a_adv_window: assert property (p_adv_window) else $error("address-valid window wrong");

  property p_oe_ken_start;
    $fell(oe_n_q) |-> $past(state_q, 2) == glue_pkg::ST_RD_CTL && !ken_n_q;
  endproperty
  a_oe_ken_start: assert property (p_oe_ken_start) else $error("output enable not at N=2");

  property p_ready_start;
    ($fell(cpu_burst_ready_n_n_q) && state_q != glue_pkg::ST_WR_READY) |-> $past(state_q, 3) == glue_pkg::ST_RD_CTL;
  endproperty
  a_ready_start: assert property (p_ready_start) else $error("burst ready not at N=3");

  property p_burst_end;
    (burst_end && cpu_backoff_n && state_q inside {glue_pkg::ST_RD_ADDR, glue_pkg::ST_RD_DATA})
      |=> cpu_burst_ready_n_n_q && ken_n_q && !oe_n_q ##1 oe_n_q && state_q == glue_pkg::ST_IDLE;
  endproperty
  a_burst_end: assert property (p_burst_end) else $error("burst end sequence wrong");

  property p_backoff;
    !cpu_backoff_n |-> flash_write_enable_n && flash_output_enable_n ##1 state_q == glue_pkg::ST_IDLE;
  endproperty
  a_backoff: assert property (p_backoff) else $error("back-off did not abort");

  property p_write_entry;
    (state_q == glue_pkg::ST_IDLE && !cpu_addr_strobe_n && cpu_write_read && cpu_backoff_n)
      |=> state_q == glue_pkg::ST_WR_LOAD && !sel_q;
  endproperty
  a_write_entry: assert property (p_write_entry) else $error("write not entered");

  property p_write_addr_hold;
    (state_q inside {glue_pkg::ST_WR_CTL, glue_pkg::ST_WR_PULSE}) |-> !sel_q && $stable(flash_low_addr);
  endproperty
  a_write_addr_hold: assert property (p_write_addr_hold) else $error("write address moved");

  property p_we_pulse;
    ($fell(we_n_q) && cpu_backoff_n) ##1 cpu_backoff_n |=> we_n_q && !cpu_burst_ready_n_n_q && !$past(we_n_q);
  endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("write strobe not two clocks");

  property p_write_finish;
    (state_q == glue_pkg::ST_WR_READY && cpu_backoff_n) |=> state_q == glue_pkg::ST_IDLE && cpu_burst_ready_n_n_q;
  endproperty
  a_write_finish: assert property (p_write_finish) else $error("write did not finish at N=5");

  property p_reset_state;
    $past(srst) |-> state_q == glue_pkg::ST_IDLE && cpu_burst_ready_n_n_q && ken_n_q && oe_n_q && we_n_q;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset left strobes active");

endmodule
`default_nettype wire

/* sim/cpu_bus_model.sv */
// Purpose: processor side of a burst read: latches words, drives burst-last
// Assumes: go is high in the cycle whose edge samples the cycle-start strobe
// Notes:   burst-last is set one clock ahead of the final ready sample
`timescale 1ns/1ns
`default_nettype none
module cpu_bus_model (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       srst,
  // cycle control from the bench
  input  wire logic       go,
  input  wire logic [2:0] last_at,
  // processor bus
  input  wire logic       cpu_burst_ready_n,
  output logic            cpu_burst_last_n,
  output logic      [2:0] words
);
  // ==========================================================================
  // word latch and burst-last
  // ==========================================================================
  // one word per ready sample; last must be early since the glue samples it
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      words            <= 3'h0;
      cpu_burst_last_n <= 1'b1;
    end
    else if (go)
    begin
      words            <= 3'h0;
      cpu_burst_last_n <= (last_at != 3'h1);
    end
    else if (!cpu_burst_ready_n)
    begin
      words            <= words + 3'h1;
      cpu_burst_last_n <= (words + 3'h2 != last_at);
    end
  end
endmodule
`default_nettype wire

/* sim/tb_top.sv */
// Purpose: self-checking bench of the flash burst glue
// Assumes: clk_en stays high; processor model answers burst reads
// Notes:   outputs are looked at 1 ns after each edge, once settled
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  // ==========================================================================
  // stimulus and observed signals
  // ==========================================================================
  logic       ref_clk = 1'b0;
  logic       srst = 1'b1;
  logic       cpu_addr_strobe_n = 1'b1;
  logic       cpu_write_read = 1'b0;
  logic       cpu_backoff_n = 1'b1;
  logic [1:0] cpu_low_addr = 2'h0;
  logic       flash_space_miss = 1'b0;
  logic       setting = 1'b0;
  logic       go = 1'b0;
  logic [2:0] last_at = 3'h4;
  logic       cpu_burst_last_n, cpu_burst_ready_n, cpu_cacheable_n;
  logic       flash_addr_valid_n, low_addr_path_select, flash_chip_enable_n;
  logic       flash_output_enable_n, flash_write_enable_n;
  logic [1:0] flash_low_addr;
  logic [2:0] words;
  int         n_mismatch = 0;
  int         check_count = 0;
  int         cycles = 0;
  // wrapping burst order, one row per start offset
  logic [1:0] wrap_order [4][4] = '{'{2'h0, 2'h1, 2'h2, 2'h3}, '{2'h1, 2'h0, 2'h3, 2'h2},
                                    '{2'h2, 2'h3, 2'h0, 2'h1}, '{2'h3, 2'h2, 2'h1, 2'h0}};

  // 25 MHz processor clock
  always #20 ref_clk = ~ref_clk;

  // ==========================================================================
  // design and processor model
  // ==========================================================================
  sync_flash_cpu_burst_glue DUT (
    .ref_clk(ref_clk), .srst(srst), .clk_en(1'b1),
    .cpu_addr_strobe_n(cpu_addr_strobe_n), .cpu_write_read(cpu_write_read),
    .cpu_burst_last_n(cpu_burst_last_n), .cpu_backoff_n(cpu_backoff_n),
    .cpu_low_addr(cpu_low_addr), .cpu_burst_ready_n(cpu_burst_ready_n),
    .cpu_cacheable_n(cpu_cacheable_n), .flash_space_miss(flash_space_miss),
    .flash_read_latency_setting(setting), .flash_addr_valid_n(flash_addr_valid_n),
    .low_addr_path_select(low_addr_path_select), .flash_chip_enable_n(flash_chip_enable_n),
    .flash_output_enable_n(flash_output_enable_n), .flash_write_enable_n(flash_write_enable_n),
    .flash_low_addr(flash_low_addr));

  cpu_bus_model proc (
    .ref_clk(ref_clk), .srst(srst), .go(go), .last_at(last_at),
    .cpu_burst_ready_n(cpu_burst_ready_n), .cpu_burst_last_n(cpu_burst_last_n), .words(words));

  // ==========================================================================
  // compares, verdict and timeout
  // ==========================================================================
  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask

  task automatic chk_addr(input logic [1:0] got, input logic [1:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: flash address %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    if (n_mismatch == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // a hang is cut short well beyond the 125 or so cycles the run needs
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_mismatch++;
      test_done();
    end
  end

  // ==========================================================================
  // bus helpers
  // ==========================================================================
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask

  // strobe for one clock; returns just after edge N=0
  task automatic launch(input logic wr, input logic [1:0] a, input logic [2:0] n);
    @(posedge ref_clk);
    cpu_addr_strobe_n <= 1'b0;
    cpu_write_read    <= wr;
    cpu_low_addr      <= a;
    last_at           <= n;
    go                <= 1'b1;
    @(posedge ref_clk);
    cpu_addr_strobe_n <= 1'b1;
    go                <= 1'b0;
    if (wr)
      cpu_low_addr <= ~a;
    #1;
  endtask

  task automatic idle_ok();
    chk_bit(flash_addr_valid_n, 1'b0);
    chk_bit(low_addr_path_select, 1'b1);
    chk_addr(flash_low_addr, cpu_low_addr);
    chk_bit(flash_chip_enable_n, 1'b0);
    chk_bit(flash_output_enable_n, 1'b1);
    chk_bit(flash_write_enable_n, 1'b1);
    chk_bit(cpu_burst_ready_n, 1'b1);
    chk_bit(cpu_cacheable_n, 1'b1);
  endtask

  // ==========================================================================
  // scenarios
  // ==========================================================================
  task automatic burst_read(input logic [1:0] a, input logic [2:0] n);
    int k;
    launch(1'b0, a, n);
    for (k = 1; k <= 3; k++)
    begin
      tick();
      chk_addr(flash_low_addr, wrap_order[a][k]);
      chk_bit(flash_addr_valid_n, 1'b0);
      chk_bit(low_addr_path_select, 1'b0);
      chk_bit(flash_output_enable_n, k < 2);
      chk_bit(cpu_cacheable_n, k < 2);
      chk_bit(cpu_burst_ready_n, k < 3);
    end
    for (k = 1; k <= n; k++)
    begin
      tick();
      chk_bit(flash_addr_valid_n, 1'b1);
      chk_bit(cpu_burst_ready_n, k == n);
      chk_bit(cpu_cacheable_n, k == n);
      chk_bit(flash_output_enable_n, 1'b0);
    end
    tick();
    idle_ok();
    chk_bit(words === n, 1'b1);
  endtask

  task automatic refused(input logic miss, input logic set, input logic wr);
    int k;
    @(posedge ref_clk);
    flash_space_miss <= miss;
    setting          <= set;
    launch(wr, 2'h1, 3'h4);
    for (k = 1; k <= 4; k++)
    begin
      tick();
      chk_bit(flash_write_enable_n, 1'b1);
      chk_bit(flash_output_enable_n, 1'b1);
      chk_bit(cpu_burst_ready_n, 1'b1);
      chk_bit(cpu_cacheable_n, 1'b1);
    end
    idle_ok();
    @(posedge ref_clk);
    flash_space_miss <= 1'b0;
    setting          <= 1'b1;
  endtask

  // slow setting during the write: it must not matter
  task automatic write_cycle(input logic [1:0] a);
    int k;
    @(posedge ref_clk);
    setting <= 1'b0;
    launch(1'b1, a, 3'h1);
    chk_bit(low_addr_path_select, 1'b0);
    chk_addr(flash_low_addr, a);
    for (k = 1; k <= 4; k++)
    begin
      tick();
      chk_addr(flash_low_addr, a);
      chk_bit(flash_write_enable_n, k == 1 || k == 4);
      chk_bit(cpu_burst_ready_n, k != 4);
    end
    tick();
    idle_ok();
    @(posedge ref_clk);
    setting <= 1'b1;
  endtask

  task automatic backoff(input logic wr);
    launch(wr, 2'h1, 3'h4);
    tick();
    @(posedge ref_clk);
    cpu_backoff_n <= 1'b0;
    #1;
    chk_bit(flash_output_enable_n, 1'b1);
    chk_bit(flash_write_enable_n, 1'b1);
    @(posedge ref_clk);
    cpu_backoff_n <= 1'b1;
    #1;
    chk_bit(cpu_burst_ready_n, 1'b1);
    chk_bit(flash_chip_enable_n, 1'b0);
    tick();
    idle_ok();
  endtask

  task automatic reset_mid();
    launch(1'b0, 2'h2, 3'h4);
    tick();
    tick();
    @(posedge ref_clk);
    srst <= 1'b1;
    @(posedge ref_clk);
    srst <= 1'b0;
    #1;
    idle_ok();
  endtask

  // ==========================================================================
  // main sequence
  // ==========================================================================
  // a slow-setting refusal, reads back to back from every start offset, then refusals, writes, aborts
  initial
  begin
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    #1;
    idle_ok();
    refused(1'b0, 1'b0, 1'b0);
    for (int i = 0; i < 4; i++)
      burst_read(i[1:0], 3'h4);
    burst_read(2'h3, 3'h1);
    refused(1'b1, 1'b1, 1'b0);
    refused(1'b1, 1'b1, 1'b1);
    write_cycle(2'h2);
    write_cycle(2'h1);
    backoff(1'b0);
    backoff(1'b1);
    reset_mid();
    burst_read(2'h2, 3'h4);
    test_done();
  end
endmodule
`default_nettype wire
